// ==== sni_pkg.sv ====
// constants, types and state codes shared by the serial nand front end
`default_nettype none
package sni_pkg;
   // page and block geometry
   localparam int SNI_PAGE_BYTES = 4352;
   localparam int SNI_MAIN_BYTES = 4096;
   localparam int SNI_SPARE_BYTES = 256;
   localparam int SNI_PAGES_PER_BLOCK = 64;
   localparam int SNI_BLOCKS = 2048;
   localparam int SNI_COL_W = 13;
   localparam int SNI_PAGE_W = 6;
   localparam int SNI_ROW_W = 17;
   localparam int SNI_SECT_BYTES = 512;
   localparam int SNI_POS_W = 12;
   // check bytes live in the spare region, two per sector
   localparam logic [12:0] SNI_ECC_BASE = 13'h1040;
   localparam logic [12:0] SNI_ECC_BYTES = 13'h0010;
   localparam logic [12:0] SNI_LAST_COL = 13'h10FF;
   localparam logic [12:0] SNI_MAIN_END = 13'h1000;
   // command codes seen on the serial input
   localparam logic [7:0] SNI_CMD_STATUS = 8'h0F;
   localparam logic [7:0] SNI_CMD_SET_ECC = 8'h1F;
   localparam logic [7:0] SNI_CMD_LOAD = 8'h02;
   localparam logic [7:0] SNI_CMD_EXEC = 8'h10;
   localparam logic [7:0] SNI_CMD_PAGE_RD = 8'h13;
   localparam logic [7:0] SNI_CMD_CACHE_RD = 8'h03;
   localparam logic [7:0] SNI_CMD_ERASE = 8'hD8;
   // status byte fields
   localparam int SNI_ST_BUSY = 0;
   localparam int SNI_ST_ECCEN = 1;
   localparam int SNI_ST_ECC = 4;
   localparam logic [1:0] SNI_ECC_OK = 2'h0;
   localparam logic [1:0] SNI_ECC_FIXED = 2'h1;
   localparam logic [1:0] SNI_ECC_BAD = 2'h2;
   // ecc enable reset value and byte counter limit
   localparam logic SNI_ECC_EN_RST = 1'b1;
   localparam logic [2:0] SNI_NBYTE_MAX = 3'h7;

   // array-side request, one word per cycle
   typedef struct packed {
      logic we;
      logic re;
      logic erase;
      logic [SNI_ROW_W-1:0] row;
      logic [SNI_COL_W-1:0] col;
      logic [7:0] wdata;
   } sni_arr_t;

   // sequencer states
   typedef enum logic [7:0] {
      SNI_IDLE = 8'h01,
      SNI_FETCH = 8'h02,
      SNI_CHECK = 8'h04,
      SNI_CMP = 8'h08,
      SNI_ENC = 8'h10,
      SNI_PUT = 8'h20,
      SNI_WRITE = 8'h40,
      SNI_ERASE = 8'h80
   } sni_state_t;
endpackage
`default_nettype wire

// ==== sni_ecc_acc.sv ====
// per-sector syndrome and parity accumulator for the on-die ecc
`default_nettype none
module sni_ecc_acc (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // byte stream
   input wire logic clr,
   input wire logic en,
   input wire logic [7:0] data,
   input wire logic [8:0] pos,
   // running result
   output logic [sni_pkg::SNI_POS_W-1:0] syn,
   output logic par
);
   import sni_pkg::*;

   logic [SNI_POS_W-1:0] syn_r;
   logic par_r;

   // xor of the bit addresses of every set bit in one byte
   function automatic logic [SNI_POS_W-1:0] contrib(input logic [7:0] d,
                                                  input logic [8:0] p);
      logic [SNI_POS_W-1:0] acc;
      acc = '0;
      for (int b = 0; b < 8; b++) begin
         if (d[b]) begin
            acc = acc ^ {p, 3'(b)};
         end
      end
      return acc;
   endfunction

   // clear wins so a new sector starts clean
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syn_r <= '0;
         par_r <= 1'b0;
      end else if (clr) begin
         syn_r <= '0;
         par_r <= 1'b0;
      end else if (en) begin
         syn_r <= syn_r ^ contrib(data, pos);
         par_r <= par_r ^ (^data);
      end
   end

   assign syn = syn_r;
   assign par = par_r;
endmodule
`default_nettype wire

// ==== sni_serial_nand.sv ====
// serial front end, page buffers and ecc sequencer of the nand device
`default_nettype none
module sni_serial_nand #(
   parameter int BLOCKS = sni_pkg::SNI_BLOCKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   // power state
   output logic active,
   output logic standby,
   // array port, read data sampled at the edge that ends the cycle re is high
   output sni_pkg::sni_arr_t arr,
   input wire logic [7:0] arr_rdata
);
   import sni_pkg::*;

   if (BLOCKS < 1 || BLOCKS > 2 ** (SNI_ROW_W - SNI_PAGE_W)) begin : g_chk
      $error("BLOCKS does not fit the row address");
   end

   logic [7:0] cache_mem [SNI_PAGE_BYTES];
   logic [7:0] data_mem [SNI_PAGE_BYTES];

   logic cs_q_r, sck_q_r, armed_r, ecc_en_r, rd_pend_r;
   logic so_r, so_oe_n_r, active_r, standby_r;
   logic [7:0] sh_r, cmd_r, out_r;
   logic [2:0] bit_r, nbyte_r;
   logic [23:0] addr_r;
   logic [12:0] col_r, idx_r, rd_col_r;
   logic [1:0] ecc_st_r;
   logic [SNI_ROW_W-1:0] row_r;
   sni_state_t state_r, state_nxt;
   sni_arr_t arr_r, arr_nxt;
   logic [SNI_POS_W-1:0] acc_syn;
   logic acc_par;

   // out-of-range columns read as erased
   function automatic logic [7:0] cache_rd(input logic [12:0] c);
      return (c <= SNI_LAST_COL) ? cache_mem[c] : 8'hFF;
   endfunction

   // pin edge decode, sck edges count only while selected
   wire cs_fall = cs_q_r & ~cs_n;
   wire cs_rise = ~cs_q_r & cs_n;
   wire sck_rise = ~cs_n & sck & ~sck_q_r;
   wire sck_fall = ~cs_n & ~sck & sck_q_r;
   wire busy = state_r != SNI_IDLE;
   wire [7:0] sh_nxt = {sh_r[6:0], si};
   wire byte_done = sck_rise & (bit_r == 3'h7) & armed_r;
   wire [7:0] cmd_now = (nbyte_r == 3'h0) ? sh_nxt : cmd_r;
   wire [12:0] col_new = {addr_r[4:0], sh_nxt};
   wire col_byte = byte_done & (nbyte_r == 3'h2);
   wire dat_byte = byte_done & (nbyte_r >= 3'h3);
   wire io_ok = ~busy;
   wire is_load = io_ok & (cmd_r == SNI_CMD_LOAD);
   wire is_crd = io_ok & (cmd_r == SNI_CMD_CACHE_RD);
   wire spi_wr = dat_byte & is_load & (col_r <= SNI_LAST_COL);
   wire [7:0] status = {2'h0, ecc_st_r, 2'h0, ecc_en_r, busy};

   // commands registered when select rises on a whole byte count
   wire whole = cs_rise & armed_r & (bit_r == 3'h0) & ~busy;
   wire go_read = whole & (nbyte_r == 3'h4) & (cmd_r == SNI_CMD_PAGE_RD);
   wire go_prog = whole & (nbyte_r == 3'h4) & (cmd_r == SNI_CMD_EXEC);
   wire go_erase = whole & (nbyte_r == 3'h4) & (cmd_r == SNI_CMD_ERASE);
   wire go_ecc = whole & (nbyte_r == 3'h2) & (cmd_r == SNI_CMD_SET_ECC);

   // sequencer decode
   // page length end point
   wire last = idx_r == SNI_LAST_COL;
   wire in_main = idx_r < SNI_MAIN_END;
   wire sect_end = ecc_en_r & in_main & (idx_r[8:0] == 9'h1FF);
   wire in_ecc = (idx_r >= SNI_ECC_BASE) &
                 (idx_r < SNI_ECC_BASE + SNI_ECC_BYTES);
   wire [12:0] chk_a = SNI_ECC_BASE + {8'h00, idx_r[11:9], 1'b0};
   wire [12:0] chk_b = chk_a + 13'h0001;
   wire [SNI_POS_W-1:0] st_syn = {data_mem[chk_a][3:0], data_mem[chk_b]};
   wire st_par = data_mem[chk_a][4];
   wire [SNI_POS_W-1:0] diff = acc_syn ^ st_syn;
   wire par_bad = acc_par ^ st_par;
   wire [12:0] fix_a = {1'b0, idx_r[11:9], diff[11:3]};
   wire acc_en = ecc_en_r & in_main &
                 (state_r == SNI_CHECK || state_r == SNI_ENC);
   wire [7:0] acc_byte = (state_r == SNI_CHECK) ? data_mem[idx_r]
                                                : cache_mem[idx_r];

   sni_ecc_acc u_acc (
      .clk(clk),
      .rst_n(rst_n),
      .clr(state_r == SNI_CMP || state_r == SNI_PUT || state_r == SNI_IDLE),
      .en(acc_en),
      .data(acc_byte),
      .pos(idx_r[8:0]),
      .syn(acc_syn),
      .par(acc_par)
   );

   // next state of the page sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SNI_IDLE: begin
            if (go_read) state_nxt = SNI_FETCH;
            else if (go_prog) state_nxt = SNI_ENC;
            else if (go_erase) state_nxt = SNI_ERASE;
         end
         SNI_FETCH: if (last) state_nxt = SNI_CHECK;
         SNI_CHECK: begin
            if (sect_end) state_nxt = SNI_CMP;
            else if (last) state_nxt = SNI_IDLE;
         end
         SNI_CMP: state_nxt = SNI_CHECK;
         SNI_ENC: begin
            if (sect_end) state_nxt = SNI_PUT;
            else if (last) state_nxt = SNI_WRITE;
         end
         SNI_PUT: state_nxt = SNI_ENC;
         SNI_WRITE: if (last) state_nxt = SNI_IDLE;
         SNI_ERASE: state_nxt = SNI_IDLE;
      endcase
   end

   // array request, one page byte or one block erase per cycle
   always_comb begin
      arr_nxt = '0;
      arr_nxt.row = row_r;
      arr_nxt.col = idx_r;
      arr_nxt.re = state_r == SNI_FETCH;
      arr_nxt.we = state_r == SNI_WRITE;
      arr_nxt.wdata = data_mem[idx_r];
      arr_nxt.erase = state_r == SNI_ERASE;
      if (state_r == SNI_ERASE) arr_nxt.row[SNI_PAGE_W-1:0] = '0;
   end

   // pin sampling and power state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // low so a select held low through reset gives no false fall
         cs_q_r <= 1'b0;
         sck_q_r <= 1'b0;
         armed_r <= 1'b0;
         active_r <= 1'b0;
         standby_r <= 1'b0;
      end else begin
         cs_q_r <= cs_n;
         sck_q_r <= sck;
         if (cs_fall) armed_r <= 1'b1;
         active_r <= ~cs_n;
         standby_r <= cs_n & ~busy & (state_nxt == SNI_IDLE);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_r <= 8'h00;
         bit_r <= 3'h0;
         nbyte_r <= 3'h0;
         cmd_r <= 8'h00;
         addr_r <= 24'h00_0000;
      end else if (cs_fall) begin
         bit_r <= 3'h0;
         nbyte_r <= 3'h0;
      end else if (sck_rise) begin
         sh_r <= sh_nxt;
         bit_r <= bit_r + 3'h1;
         if (byte_done && nbyte_r == 3'h0) cmd_r <= sh_nxt;
         if (byte_done && nbyte_r != 3'h0) addr_r <= {addr_r[15:0], sh_nxt};
         if (byte_done && nbyte_r != SNI_NBYTE_MAX) nbyte_r <= nbyte_r + 3'h1;
      end
   end

   // column pointer and output byte from cache or status
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         col_r <= 13'h0000;
         out_r <= 8'h00;
      end else if (byte_done) begin
         if (cmd_now == SNI_CMD_STATUS) out_r <= status;
         if (col_byte && is_crd) out_r <= cache_rd(col_new);
         if (dat_byte && is_crd) out_r <= cache_rd(col_r);
         if (col_byte) col_r <= (is_crd) ? col_new + 13'h0001 : col_new;
         if (dat_byte) col_r <= col_r + 13'h0001;
      end
   end

   // serial output driver
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         so_r <= 1'b0;
         so_oe_n_r <= 1'b1;
      end else if (cs_n) begin
         so_oe_n_r <= 1'b1;
      end else if (sck_fall) begin
         // shift out on falling edges, modes 0 and 3 alike
         so_r <= out_r[3'h7 - bit_r];
         so_oe_n_r <= 1'b0;
      end
   end

   // sequencer registers and ecc control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= SNI_IDLE;
         idx_r <= 13'h0000;
         row_r <= '0;
         rd_pend_r <= 1'b0;
         rd_col_r <= 13'h0000;
         // boot block read with ecc on
         ecc_en_r <= SNI_ECC_EN_RST;
         ecc_st_r <= SNI_ECC_OK;
         arr_r <= '0;
      end else begin
         state_r <= state_nxt;
         arr_r <= arr_nxt;
         rd_pend_r <= state_r == SNI_FETCH;
         rd_col_r <= idx_r;
         if (go_read || go_prog || go_erase) begin
            row_r <= addr_r[SNI_ROW_W-1:0];
            idx_r <= 13'h0000;
         end
         if (go_read) ecc_st_r <= SNI_ECC_OK;
         if (go_ecc) ecc_en_r <= addr_r[0];
         if (state_r != SNI_IDLE && state_r != SNI_ERASE) begin
            if (last && state_nxt != SNI_CMP && state_nxt != SNI_PUT) begin
               idx_r <= 13'h0000;
            end else if (state_nxt == state_r || state_r == SNI_CMP ||
                         state_r == SNI_PUT) begin
               idx_r <= idx_r + 13'h0001;
            end
         end
         // single flips fixed, double errors flagged
         if (state_r == SNI_CMP && par_bad && ecc_st_r != SNI_ECC_BAD) begin
            ecc_st_r <= SNI_ECC_FIXED;
         end
         if (state_r == SNI_CMP && !par_bad && diff != '0) begin
            ecc_st_r <= SNI_ECC_BAD;
         end
      end
   end

   // cache register writes: serial load, page copy, correction
   always_ff @(posedge clk) begin
      if (spi_wr) begin
         cache_mem[col_r] <= sh_nxt;
      end else if (state_r == SNI_CHECK) begin
         cache_mem[idx_r] <= data_mem[idx_r];
      end else if (state_r == SNI_CMP && par_bad) begin
         cache_mem[fix_a][diff[2:0]] <= ~cache_mem[fix_a][diff[2:0]];
      end
   end

   // data register writes: array fetch, encode copy, check bytes
   always_ff @(posedge clk) begin
      if (rd_pend_r) begin
         data_mem[rd_col_r] <= arr_rdata;
      end else if (state_r == SNI_ENC && !(ecc_en_r && in_ecc)) begin
         data_mem[idx_r] <= cache_mem[idx_r];
      end else if (state_r == SNI_PUT) begin
         data_mem[chk_a] <= {3'h0, acc_par, acc_syn[11:8]};
         data_mem[chk_b] <= acc_syn[7:0];
      end
   end

   assign so = so_r;
   assign so_oe_n = so_oe_n_r;
   assign active = active_r;
   assign standby = standby_r;
   assign arr = arr_r;

   // checks on the pins and the sequencer
   so_float_a: assert property (@(posedge clk) disable iff (!rst_n)
      cs_n |=> so_oe_n) else $error("output driven while deselected");
   act_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cs_n |=> active) else $error("not active while selected");
   standby_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      standby |-> !busy && $past(cs_n)) else $error("standby while busy");
   unarmed_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !armed_r |-> state_r == SNI_IDLE && !go_ecc)
      else $error("command before first select fall");
   start_at_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(busy) |-> $past(cs_rise) && $past(cs_n))
      else $error("operation began without select rise");
   sample_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
      sck_rise |=> sh_r[0] == $past(si))
      else $error("input bit not sampled");
   so_change_a: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(so) |-> $past(sck_fall)) else $error("output moved off edge");
   ecc_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(ecc_en_r) |-> $past(go_ecc)) else $error("ecc dropped alone");
   page_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      busy |-> idx_r <= SNI_LAST_COL) else $error("index past page");
   erase_blk_a: assert property (@(posedge clk) disable iff (!rst_n)
      arr.erase |-> arr.row[5:0] == 6'h00 && $past(state_r) == SNI_ERASE)
      else $error("erase not block aligned");
   uncorr_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == SNI_CMP && !par_bad && diff != '0 |=> ecc_st_r == SNI_ECC_BAD)
      else $error("uncorrectable not reported");
endmodule
`default_nettype wire

// ==== sni_host_model.sv ====
// serial host model that frames commands and collects answer bytes
`default_nettype none
module sni_host_model (
   // clock
   input wire logic clk,
   // serial pins from the device
   input wire logic so,
   input wire logic so_oe_n,
   // serial pins to the device
   output logic cs_n,
   output logic sck,
   output logic si
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mode3 = 1'b0;
   logic [7:0] rx [$];

   // idle bus at time zero
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end

   // pins change at falling clk edges only
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic set_mode(input logic m);
      mode3 = m;
      sck = m;
      wait_clk(2);
   endtask

   // one framed transfer, msb first, answer bytes kept in rx
   task automatic xfer(input logic [7:0] tx [$]);
      logic [7:0] b;
      rx = {};
      cs_n = 1'b0;
      wait_clk(2);
      foreach (tx[i]) begin
         for (int k = 7; k >= 0; k--) begin
            sck = 1'b0;
            si = tx[i][k];
            wait_clk(2);
            b[k] = so;
            sck = 1'b1;
            wait_clk(2);
         end
         rx.push_back(b);
      end
      sck = mode3;
      wait_clk(2);
      // select rises after the whole sequence
      cs_n = 1'b1;
      // released line shows the inverse of its last bit
      si = ~si;
      wait_clk(2);
   endtask
endmodule
`default_nettype wire

// ==== tb_serial_nand_interface.sv ====
// self-checking bench for the serial nand front end
`default_nettype none
module tb_serial_nand_interface import sni_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cs_n, sck, si, so, so_oe_n, active, standby;
   sni_arr_t arr;
   logic [7:0] arr_rdata = 8'h00;
   logic [7:0] mem [logic [29:0]];
   int n_re, n_we, n_er, early, fail_count, n_tests;

   // clock generator
   always #12.5 clk = ~clk;

   sni_serial_nand uut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
      .si(si), .so(so), .so_oe_n(so_oe_n), .active(active),
      .standby(standby), .arr(arr), .arr_rdata(arr_rdata));

   sni_host_model host (.clk(clk), .so(so), .so_oe_n(so_oe_n),
      .cs_n(cs_n), .sck(sck), .si(si));

   // array model, erased cells read as ff
   always @(posedge clk) begin
      if (!cs_n && (arr.re || arr.we || arr.erase)) early++;
      if (arr.we) begin
         n_we++;
         mem[{arr.row, arr.col}] = arr.wdata;
      end
      if (arr.erase) begin
         n_er++;
         for (int p = 0; p < 64; p++)
            for (int c = 0; c < SNI_PAGE_BYTES; c++)
               mem.delete({arr.row[16:6], p[5:0], c[12:0]});
      end
   end

   // read data answers in the cycle that re stands, driven mid cycle
   always @(negedge clk) begin
      if (arr.re) begin
         n_re++;
         arr_rdata <= mem.exists({arr.row, arr.col}) ?
            mem[{arr.row, arr.col}] : 8'hFF;
      end
   end

   task automatic chk_val(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp,
      input logic got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // expected status byte from ecc outcome and enable
   function automatic logic [7:0] exp_st(input logic [1:0] ecc,
      input logic en);
      exp_st = 8'h00;
      exp_st[SNI_ST_ECCEN] = en;
      exp_st[SNI_ST_ECC +: 2] = ecc;
   endfunction

   // status read, pins checked once deselected
   task automatic get_status(output logic [7:0] st);
      host.xfer({SNI_CMD_STATUS, 8'h00});
      st = host.rx[1];
      chk_bit("so_oe_n", 1'b1, so_oe_n);
      chk_bit("active", 1'b0, active);
      chk_bit("standby", 1'b1, standby);
   endtask

   // row command, then wait for standby and count array cycles
   task automatic row_op(input logic [7:0] op, input logic [16:0] r,
      input int exp);
      int w;
      n_re = 0;
      n_we = 0;
      n_er = 0;
      host.xfer({op, 8'(r[16]), r[15:8], r[7:0]});
      if (op != SNI_CMD_ERASE) chk_bit("standby", 1'b0, standby);
      w = 0;
      // wait for the array to finish
      while (standby !== 1'b1 && w < 20000) begin
         @(negedge clk);
         w++;
      end
      chk_bit("standby", 1'b1, standby);
      chk_val("array cycles", 16'(exp), 16'(op == SNI_CMD_EXEC ? n_we :
         op == SNI_CMD_ERASE ? n_er : n_re));
   endtask

   task automatic col_cmd(input logic [7:0] op, input logic [12:0] c,
      input logic [7:0] dat [$]);
      host.xfer({op, 8'(c[12:8]), c[7:0], dat});
   endtask

   // cache read from a column, compared byte by byte
   task automatic rd_cmp(input logic [12:0] c, input logic [7:0] e [$]);
      logic [7:0] z [$];
      foreach (e[i]) z.push_back(8'h00);
      col_cmd(SNI_CMD_CACHE_RD, c, z);
      foreach (e[i]) chk_val("cache byte", 16'(e[i]), 16'(host.rx[3+i]));
   endtask

   task automatic tdone(input string name);
      $display("test %s finished", name);
   endtask

   // watchdog sized above the longest expected run
   initial begin
      #(99000 * 25);
      fail_count++;
      close_out();
   end

   initial begin
      logic [7:0] st;
      logic [7:0] d [$];
      logic [7:0] f [$];
      logic [16:0] row;
      logic [12:0] col;
      void'($urandom(32'hff682750));
      #1 host.cs_n = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      host.xfer({SNI_CMD_SET_ECC, 8'h00});
      get_status(st);
      chk_val("status", 16'(exp_st(SNI_ECC_OK, 1'b1)), 16'(st));
      host.cs_n = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit("active", 1'b1, active);
      host.cs_n = 1'b1;
      repeat (2) @(negedge clk);
      tdone("arming");
      host.xfer({SNI_CMD_SET_ECC, 8'h00});
      get_status(st);
      chk_val("status", 16'(exp_st(SNI_ECC_OK, 1'b0)), 16'(st));
      row = 17'($urandom);
      col = 13'($urandom % 480);
      row_op(SNI_CMD_PAGE_RD, row, SNI_PAGE_BYTES);
      tdone("ecc off read");
      host.xfer({SNI_CMD_SET_ECC, 8'h01});
      for (int i = 0; i < 16; i++) d.push_back(8'($urandom));
      host.set_mode(1'b1);
      col_cmd(SNI_CMD_LOAD, col, d);
      host.set_mode(1'b0);
      row_op(SNI_CMD_EXEC, row, SNI_PAGE_BYTES);
      row_op(SNI_CMD_PAGE_RD, row, SNI_PAGE_BYTES);
      get_status(st);
      chk_val("status", 16'(exp_st(SNI_ECC_OK, 1'b1)), 16'(st));
      rd_cmp(col, d);
      tdone("program and read");
      mem[{row, col}] ^= 8'h01;
      row_op(SNI_CMD_PAGE_RD, row, SNI_PAGE_BYTES);
      get_status(st);
      chk_val("status", 16'(exp_st(SNI_ECC_FIXED, 1'b1)), 16'(st));
      rd_cmp(col, d);
      mem[{row, col + 13'h0001}] ^= 8'h04;
      row_op(SNI_CMD_PAGE_RD, row, SNI_PAGE_BYTES);
      get_status(st);
      chk_val("status", 16'(exp_st(SNI_ECC_BAD, 1'b1)), 16'(st));
      tdone("ecc correction");
      row_op(SNI_CMD_ERASE, row, 1);
      host.xfer({SNI_CMD_SET_ECC, 8'h00});
      row_op(SNI_CMD_PAGE_RD, row, SNI_PAGE_BYTES);
      repeat (4) f.push_back(8'hFF);
      rd_cmp(col, f);
      tdone("erase");
      col_cmd(SNI_CMD_LOAD, 13'h1100, {8'hAA});
      rd_cmp(13'h1100, f);
      chk_val("early array ops", 16'h0000, 16'(early));
      tdone("bounds");
      close_out();
   end
endmodule
`default_nettype wire
